// ==== remappable_pin_select_matrix_tb_top.sv ====
// Purpose: self-checking bench for the remappable pin select matrix
// Assumes: small package build, so the pin 5 field is absent
// Notes:   random register contents from a fixed lfsr seed
module remappable_pin_select_matrix_tb_top
  import rpsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata, q, rnd = 32'h5e42;
  logic        waitrequest, s2, u4c, u4r, s3c, s3d, s3s;
  logic [63:0] remappablePin, funcOut, pinSet = 64'h0, funcSet = 64'h0;
  logic [7:0]  pinOut;
  logic [15:0] sh [8];
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #12.5 clk = ~clk;

  rpsm_pad_model rpsm_pad_model_inst (.clk(clk), .pinSet(pinSet),
    .funcSet(funcSet), .remappablePin(remappablePin), .funcOut(funcOut));

  rpsm_matrix #(.SMALL_PKG(1'b1)) rpsm_matrix_inst (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .remappablePin(remappablePin),
    .funcOut(funcOut), .pinOut(pinOut), .spi2SlaveSelect(s2),
    .uart4ClearToSend(u4c), .uart4Receive(u4r), .spi3ClockInput(s3c),
    .spi3DataInput(s3d), .spi3SlaveSelect(s3s));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // implemented bits per word; the pin 5 field is absent in this build
  function automatic logic [15:0] fmask(input int w);
    if (w == 0 || w == 3 || w == 6)
      return 16'h003f;
    return 16'h3f3f;
  endfunction : fmask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address    <= a;
    read       <= !wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic chk_reset();
    for (int w = 0; w < 8; w++)
    begin
      bus(1'b0, w[3:0], 32'h0, 4'hf);
      chk(q, (w < 4) ? {16'h0, fmask(w) & 16'h3f3f}
                     : 32'h0);
    end
  endtask : chk_reset

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_reset();
    $display("test reset values done");
    for (int r = 0; r < 16; r++)
    begin
      for (int w = 0; w < 8; w++)
      begin
        rnd = (r == 0) ? 32'hffffffff : lfsr(rnd);
        bus(1'b1, w[3:0], rnd, 4'hf);
        sh[w] = rnd[15:0] & fmask(w);
      end
      rnd = lfsr(rnd);
      pinSet[31:0] <= rnd;
      rnd = lfsr(rnd);
      pinSet[63:32] <= rnd;
      funcSet <= {rnd, ~rnd};
      repeat (6) @(posedge clk);
      chk(s2, pinSet[sh[0][5:0]]);
      chk({u4c, u4r}, {pinSet[sh[1][13:8]], pinSet[sh[1][5:0]]});
      chk({s3c, s3d}, {pinSet[sh[2][13:8]], pinSet[sh[2][5:0]]});
      chk(s3s, pinSet[sh[3][5:0]]);
      for (int k = 0; k < 8; k++)
        chk(pinOut[k],
            funcSet[sh[4 + k / 2][8 * k[0] +: 6]]);
      for (int w = 0; w < 8; w++)
      begin
        bus(1'b0, w[3:0], 32'h0, 4'hf);
        chk(q, {16'h0, sh[w]});
      end
    end
    $display("test random routing done");
    bus(1'b1, 4'h1, 32'h00002a15, 4'h1);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    chk(q, {16'h0, sh[1][15:8], 8'h15});
    bus(1'b1, 4'h9, 32'hffffffff, 4'hf);
    bus(1'b0, 4'h9, 32'h0, 4'hf);
    chk(q, UNMAPPED_READ);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(q, {16'h0, sh[0]});
    $display("test lanes and unmapped done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_reset();
    $display("test mid-run reset done");
    close_out();
  end
endmodule : remappable_pin_select_matrix_tb_top

// ==== rpsm_matrix.sv ====
// Purpose: remappable pin routing with Avalon-MM configuration registers
// Assumes: pins arrive asynchronously and are synchronised here
// Notes:   one wait state per access; unmapped reads return zero
//
// The address map and the Avalon-MM slave port were left to the implementer.
module rpsm_matrix
  import rpsm_pkg::*;
#(
  parameter int NUM_PINS  = 64,
  parameter int NUM_FUNCS = 64,
  parameter bit SMALL_PKG = 1'b0
)(
  input  wire logic                 clk,              // 40 MHz clock
  input  wire logic                 nrst,             // async reset, low
  input  wire logic [3:0]           address,          // avalon word addr
  input  wire logic                 read,             // avalon read
  input  wire logic                 write,            // avalon write
  input  wire logic [31:0]          writedata,        // avalon write data
  input  wire logic [3:0]           byteenable,       // avalon byte lanes
  output logic [31:0]               readdata,         // avalon read data
  output logic                      waitrequest,      // avalon wait
  input  wire logic [NUM_PINS-1:0]  remappablePin,    // pin levels in
  input  wire logic [NUM_FUNCS-1:0] funcOut,          // peripheral outputs
  output logic [7:0]                pinOut,           // pins 0..7 out
  output logic                      spi2SlaveSelect,  // spi2 ss input
  output logic                      uart4ClearToSend, // uart4 cts input
  output logic                      uart4Receive,     // uart4 rx input
  output logic                      spi3ClockInput,   // spi3 sck input
  output logic                      spi3DataInput,    // spi3 sdi input
  output logic                      spi3SlaveSelect   // spi3 ss input
);
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [5:0]          ss2Src;
    logic [5:0]          u4CtsSrc;
    logic [5:0]          u4RxSrc;
    logic [5:0]          sck3Src;
    logic [5:0]          sdi3Src;
    logic [5:0]          ss3Src;
    logic [7:0][5:0]     outFn;
    logic [31:0]         rdata;
    logic                wait_;
    logic [7:0]          pins;
    logic                ss2;
    logic                cts4;
    logic                rx4;
    logic                sck3;
    logic                spi3_data_input;
    logic                ss3;
  } rpsm_state_s;

  rpsm_state_s state_reg;
  rpsm_state_s state_next;
  logic [7:0]  pinSel;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_out
      rpsm_out_sel #(.NUM_FUNCS(NUM_FUNCS)) u_sel (
        .funcOut  (funcOut),
        .sel      (state_reg.outFn[gi]),
        .pinValue (pinSel[gi])
      );
    end
  endgenerate

  function automatic logic pick(input logic [NUM_PINS-1:0] p,
                                input logic [5:0] s);
    pick = (int'(s) < NUM_PINS) ? p[s] : 1'b0;
  endfunction : pick

  function automatic logic [15:0] pair(input logic [5:0] hi,
                                       input logic [5:0] lo);
    pair = {2'b00, hi, 2'b00, lo}; // see RULE_09
  endfunction : pair

  logic       doWrite;
  logic       doRead;
  int         outIdx;

  always_comb
  begin
    state_next = state_reg;
    doWrite = write && state_reg.wait_;
    doRead  = read && state_reg.wait_ && !write;
    outIdx = int'(address) - OUT_BASE_WORD;
    state_next.sync1 = remappablePin;
    state_next.sync2 = state_reg.sync1;
    // one-cycle wait then ack: rdata and ack registered together
    state_next.wait_ = !((read || write) && state_reg.wait_);
    if (doWrite && byteenable[0])
    begin
      // only defined bits stored; unused bits drop writes, see RULE_11
      case (address)
        OFS_SPI2_SS: state_next.ss2Src = writedata[5:0]; // see RULE_01
        OFS_UART4: state_next.u4RxSrc = writedata[5:0]; // see RULE_02
        OFS_SPI3_CKDAT: state_next.sdi3Src = writedata[5:0]; // see RULE_03
        OFS_SPI3_SS: state_next.ss3Src = writedata[5:0]; // see RULE_04
        default:
          if (outIdx >= 0 && outIdx < NUM_OUT_REGS)
            state_next.outFn[2*outIdx] = writedata[5:0]; // see RULE_07
      endcase
    end
    if (doWrite && byteenable[1])
    begin
      case (address)
        OFS_UART4: state_next.u4CtsSrc = writedata[13:8]; // see RULE_02
        OFS_SPI3_CKDAT: state_next.sck3Src = writedata[13:8]; // see RULE_03
        default:
          if (outIdx >= 0 && outIdx < NUM_OUT_REGS)
            state_next.outFn[2*outIdx+1] = writedata[13:8]; // see RULE_07
      endcase
    end
    if (SMALL_PKG)
      state_next.outFn[SMALL_PIN] = OUT_RESET; // see RULE_10
    state_next.rdata = UNMAPPED_READ;
    if (doRead)
    begin
      case (address)
        OFS_SPI2_SS:
          state_next.rdata = {16'h0000, pair(6'h00, state_reg.ss2Src)};
        OFS_UART4:
          state_next.rdata = {16'h0000,
                              pair(state_reg.u4CtsSrc, state_reg.u4RxSrc)};
        OFS_SPI3_CKDAT:
          state_next.rdata = {16'h0000,
                              pair(state_reg.sck3Src, state_reg.sdi3Src)};
        OFS_SPI3_SS:
          state_next.rdata = {16'h0000, pair(6'h00, state_reg.ss3Src)};
        default:
          if (outIdx >= 0 && outIdx < NUM_OUT_REGS)
            state_next.rdata = {16'h0000,
                                pair(state_reg.outFn[2*outIdx+1],
                                     state_reg.outFn[2*outIdx])};
      endcase
    end
    // routing uses stored fields, so a write shows one cycle later
    state_next.ss2  = pick(state_reg.sync2, state_reg.ss2Src);   // see RULE_01
    state_next.cts4 = pick(state_reg.sync2, state_reg.u4CtsSrc); // see RULE_02
    state_next.rx4  = pick(state_reg.sync2, state_reg.u4RxSrc);  // see RULE_02
    state_next.sck3 = pick(state_reg.sync2, state_reg.sck3Src);  // see RULE_03
    state_next.spi3_data_input = pick(state_reg.sync2, state_reg.sdi3Src);  // see RULE_03
    state_next.ss3  = pick(state_reg.sync2, state_reg.ss3Src);   // see RULE_04
    state_next.pins = pinSel; // see RULE_06
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg          <= '0;
      state_reg.ss2Src   <= IN_RESET; // see RULE_05
      state_reg.u4CtsSrc <= IN_RESET;
      state_reg.u4RxSrc  <= IN_RESET;
      state_reg.sck3Src  <= IN_RESET;
      state_reg.sdi3Src  <= IN_RESET;
      state_reg.ss3Src   <= IN_RESET;
      state_reg.outFn    <= {8{OUT_RESET}}; // see RULE_08
      state_reg.wait_    <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign readdata         = state_reg.rdata;
  assign waitrequest      = state_reg.wait_;
  assign pinOut           = state_reg.pins;
  assign spi2SlaveSelect  = state_reg.ss2;
  assign uart4ClearToSend = state_reg.cts4;
  assign uart4Receive     = state_reg.rx4;
  assign spi3ClockInput   = state_reg.sck3;
  assign spi3DataInput    = state_reg.spi3_data_input;
  assign spi3SlaveSelect  = state_reg.ss3;

  property p_in_reset;
    @(posedge clk) $rose(nrst) |-> state_reg.ss3Src == IN_RESET &&
      state_reg.ss2Src == IN_RESET && state_reg.u4CtsSrc == IN_RESET &&
      state_reg.u4RxSrc == IN_RESET && state_reg.sck3Src == IN_RESET &&
      state_reg.sdi3Src == IN_RESET;
  endproperty
  a_in_reset: assert property (p_in_reset) // see RULE_05
    else $error("input selector not all ones after reset");

  property p_out_reset;
    @(posedge clk) $rose(nrst) |-> state_reg.outFn == {8{OUT_RESET}};
  endproperty
  a_out_reset: assert property (p_out_reset) // see RULE_08
    else $error("output field not zero after reset");

  property p_ss2_route;
    @(posedge clk) disable iff (!nrst)
      $stable(state_reg.ss2Src) |=>
        spi2SlaveSelect == 1'($past(state_reg.sync2) >>
                              $past(state_reg.ss2Src));
  endproperty
  a_ss2_route: assert property (p_ss2_route) // see RULE_01
    else $error("spi2 slave select misrouted");

  property p_rx4_route;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> uart4Receive == 1'($past(state_reg.sync2) >>
                                  $past(state_reg.u4RxSrc));
  endproperty
  a_rx4_route: assert property (p_rx4_route) // see RULE_02
    else $error("uart4 receive misrouted");

  property p_sck3_route;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> spi3ClockInput == 1'($past(state_reg.sync2) >>
                                    $past(state_reg.sck3Src));
  endproperty
  a_sck3_route: assert property (p_sck3_route) // see RULE_03
    else $error("spi3 clock misrouted");

  property p_ss3_route;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> spi3SlaveSelect == 1'($past(state_reg.sync2) >>
                                     $past(state_reg.ss3Src));
  endproperty
  a_ss3_route: assert property (p_ss3_route) // see RULE_04
    else $error("spi3 slave select misrouted");

  property p_pin_drive;
    @(posedge clk) disable iff (!nrst)
      (int'(state_reg.outFn[1]) < NUM_FUNCS) |=>
        pinOut[1] == 1'($past(funcOut) >> $past(state_reg.outFn[1]));
  endproperty
  a_pin_drive: assert property (p_pin_drive) // see RULE_06
    else $error("pin 1 not driven by selected function");

  property p_unused_zero;
    @(posedge clk) disable iff (!nrst)
      1'b1 |-> (readdata[31:14] == '0) && (readdata[7:6] == 2'b00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) // see RULE_09
    else $error("unused read bits not zero");

  property p_small_pkg;
    @(posedge clk) disable iff (!nrst)
      SMALL_PKG |=> state_reg.outFn[SMALL_PIN] == OUT_RESET;
  endproperty
  a_small_pkg: assert property (p_small_pkg) // see RULE_10
    else $error("pin 5 field implemented on small package");

  property p_odd_field;
    @(posedge clk) disable iff (!nrst)
      (write && !waitrequest && address == 4'h4 && byteenable[1]) |->
        state_reg.outFn[1] == $past(writedata[13:8]);
  endproperty
  a_odd_field: assert property (p_odd_field) // see RULE_07 RULE_11
    else $error("odd pin field not taken from upper bits");

  property p_cts4_route;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> uart4ClearToSend == 1'($past(state_reg.sync2) >>
                                      $past(state_reg.u4CtsSrc));
  endproperty
  a_cts4_route: assert property (p_cts4_route) // see RULE_02
    else $error("uart4 clear to send misrouted");

  property p_spi3_data_input_route;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> spi3DataInput == 1'($past(state_reg.sync2) >>
                                   $past(state_reg.sdi3Src));
  endproperty
  a_spi3_data_input_route: assert property (p_spi3_data_input_route) // see RULE_03
    else $error("spi3 data input misrouted");

  property p_pin0_drive;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> pinOut[0] == 1'($past(funcOut) >> $past(state_reg.outFn[0]));
  endproperty
  a_pin0_drive: assert property (p_pin0_drive) // see RULE_06
    else $error("pin 0 not driven by selected function");

  property p_even_field;
    @(posedge clk) disable iff (!nrst)
      (write && waitrequest && int'(address) == OUT_BASE_WORD &&
       byteenable[0]) |=> state_reg.outFn[0] == $past(writedata[5:0]);
  endproperty
  a_even_field: assert property (p_even_field) // see RULE_07
    else $error("even pin field not taken from lower bits");

  property p_apply_next;
    @(posedge clk) disable iff (!nrst)
      (write && waitrequest && address == OFS_SPI2_SS && byteenable[0]) |=>
        state_reg.ss2Src == $past(writedata[5:0]);
  endproperty
  a_apply_next: assert property (p_apply_next) // see RULE_01 RULE_11
    else $error("selector write not applied at next edge");

  property p_lane_keep;
    @(posedge clk) disable iff (!nrst)
      (write && waitrequest && address == OFS_UART4 && !byteenable[1]) |=>
        $stable(state_reg.u4CtsSrc);
  endproperty
  a_lane_keep: assert property (p_lane_keep) // see RULE_11
    else $error("disabled byte lane changed a field");

  property p_unmapped_read;
    @(posedge clk) disable iff (!nrst)
      (read && waitrequest && int'(address) >= OUT_BASE_WORD + NUM_OUT_REGS)
        |=> readdata == UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // see RULE_09
    else $error("unmapped word read not zero");
endmodule : rpsm_matrix

// ==== rpsm_out_sel.sv ====
// Purpose: one output pin selector
// Assumes: function number n drives the pin; out-of-range n gives zero
// Notes:   combinational, registered by the top
module rpsm_out_sel
  import rpsm_pkg::*;
#(
  parameter int NUM_FUNCS = 64
)(
  input  wire logic [NUM_FUNCS-1:0] funcOut,  // peripheral output functions
  input  wire logic [FIELD_W-1:0]   sel,      // mapping field value
  output logic                      pinValue  // selected value
);
  always_comb
  begin
    pinValue = (int'(sel) < NUM_FUNCS) ? funcOut[sel] : 1'b0; // see RULE_06
  end
endmodule : rpsm_out_sel

// ==== rpsm_pad_model.sv ====
// Purpose: far-side model of pads and peripheral output functions
// Assumes: levels come from the bench random source
// Notes:   both launch on clk; pads are then synchronised by the block
module rpsm_pad_model
(
  input  wire logic        clk,                   // system clock
  input  wire logic [63:0] pinSet,                // wanted pad levels
  input  wire logic [63:0] funcSet,               // wanted function levels
  output logic      [63:0] remappablePin = 64'h0, // pad levels
  output logic      [63:0] funcOut = 64'h0        // peripheral outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge clk)
  begin
    remappablePin <= pinSet;
    funcOut       <= funcSet;
  end
endmodule : rpsm_pad_model

// ==== rpsm_pkg.sv ====
// Purpose: constants for the remappable pin select matrix
// Assumes: 16-bit registers, one per aligned 32-bit Avalon word
// Notes:   offsets are avalon word addresses
// Behaviour
// RULE_01: spi2 slave select follows its 6-bit selector
// RULE_02: uart4 cts high field, receive low field
// RULE_03: spi3 clock high field, data low field
// RULE_04: spi3 slave select follows low-byte selector
// RULE_05: input selector fields reset to all ones
// RULE_06: pin driven by function numbered by field
// RULE_07: odd pin upper field, even pin lower
// RULE_08: output mapping fields reset to zero
// RULE_09: unused register bits read as zero
// RULE_10: small package drops pin 5 field, reads zero
// RULE_11: unused writes ignored; change applies next cycle
package rpsm_pkg;
  localparam int          FIELD_W        = 6;
  localparam int          HI_LSB         = 8;
  localparam int          LO_LSB         = 0;
  localparam logic [3:0]  OFS_SPI2_SS    = 4'h0;
  localparam logic [3:0]  OFS_UART4      = 4'h1;
  localparam logic [3:0]  OFS_SPI3_CKDAT = 4'h2;
  localparam logic [3:0]  OFS_SPI3_SS    = 4'h3;
  localparam int          OUT_BASE_WORD  = 4;
  localparam int          NUM_OUT_REGS   = 4;
  localparam logic [5:0]  IN_RESET       = 6'h3f;
  localparam logic [5:0]  OUT_RESET      = 6'h00;
  localparam int          SMALL_PIN      = 5;
  localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;
endpackage : rpsm_pkg
